// ==== logic/pscx_pkg.sv ====
// Constants of the peripheral system controller
`default_nettype none
package pscx_pkg;
  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int ADDR_W = 14;
  localparam int DATA_W = 16;
  localparam int PM_W = 24;
  localparam int PIO_N = 9;
  localparam int SRC_N = 8;
  // ----------------------------------------
  // Register offsets in data memory space
  // ----------------------------------------
  localparam logic [13:0] PIO_IEN_LO_ADDR = 14'h2006;
  localparam logic [13:0] PIO_FLG_LO_ADDR = 14'h2007;
  localparam logic [13:0] MODE_ADDR = 14'h2015;
  localparam logic [13:0] SYSTEM_STATUS_ADDR = 14'h2016;
  localparam logic [13:0] IRQSTAT_ADDR = 14'h2017;
  localparam logic [13:0] PIO_IEN_HI_ADDR = 14'h2046;
  localparam logic [13:0] PIO_FLG_HI_ADDR = 14'h2047;
  localparam logic [13:0] SWT_ADDR = 14'h2061;
  localparam logic [13:0] SYSCTL_ADDR = 14'h3fff;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int MODE_ADCMUX_LSB = 0;
  localparam int MODE_CONVT_BIT = 2;
  localparam int MODE_PWMUPD_BIT = 3;
  localparam int MODE_RXSEL_BIT = 4;
  localparam int MODE_UART_BIT = 5;
  localparam int MODE_AUXMODE_BIT = 6;
  localparam int MODE_SYNCEN_BIT = 7;
  localparam int MODE_TRIPEN_BIT = 8;
  localparam int IRQ_SYNC_BIT = 0;
  localparam int IRQ_TRIP_BIT = 1;
  localparam int SYSCTL_ALT_BIT = 10;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [8:0] MODE_RST = 9'h000;
  localparam logic [15:0] SYSCTL_RST = 16'h0000;
  localparam logic [8:0] PIO_IEN_RST = 9'h000;
  // ----------------------------------------
  // Vector table
  // ----------------------------------------
  localparam logic [13:0] VEC_LAST = 14'h002f;
  localparam int VEC_WORDS = 4;
  // Sources in priority order, index 0 highest
  localparam logic [13:0] VEC_ADDR [0:SRC_N-1] = '{
    14'h002c, 14'h000c, 14'h0008, 14'h0018,
    14'h001c, 14'h0020, 14'h0024, 14'h0028};
  typedef enum logic [1:0] {
    PSCX_BOOT_IDLE = 2'b00,
    PSCX_BOOT_COPY = 2'b01,
    PSCX_BOOT_DONE = 2'b10
  } pscx_boot_t;
endpackage
`default_nettype wire

// ==== logic/pscx_edge.sv ====
// Per-bit rise and fall detector
`timescale 1ns/100ps
`default_nettype none
module pscx_edge #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);
  logic armed_r;
  logic [W-1:0] prev_r;
  // No edge on the first cycle, so a high pin at release is not a rise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= ~clr_i;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < W; gi++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          prev_r[gi] <= 1'b0;
        end else begin
          prev_r[gi] <= d_i[gi];
        end
      end
      assign rise_o[gi] = armed_r & d_i[gi] & ~prev_r[gi];
      assign fall_o[gi] = armed_r & ~d_i[gi] & prev_r[gi];
    end
  endgenerate
endmodule
`default_nettype wire

// ==== logic/pscx_ctrl.sv ====
// Peripheral system controller top
// Contract
// - After reset copy default vector table into program RAM 0x0000..0x002F.
// - Each source owns four consecutive vector table words.
// - Unmasked interrupts are vectored one clock after the request, through the registered vector output.
// - Timer, serial and software interrupts vector to their own table slot.
// - Peripheral events set bits in status or pin-change flag registers.
// - Shared low-active line stays low while anything is pending.
// - All peripheral sources merge into one core interrupt line.
// - Simultaneous interrupts serve the highest priority source first.
// - Reading peripheral status clears sync and shutdown bits.
// - Reading pin-change flag registers clears all their bits.
// - Software enables or disables shutdown and sync interrupts.
// - System status shows shutdown pin, watchdog and PWM timer state.
// - Hardware, software or watchdog reset returns peripherals to reset state.
// - Mode register drives converter, PWM update and auxiliary PWM modes.
// - Mode bit 4 selects second receive pin, else first.
// - Mode bit 5 selects UART emulation, tying receive data and frame sync.
// - UART emulation drives core flag onto pin five.
// - Control bit 10 makes receive pin flag input, transmit pin flag output.
// - Alternate mode routes frame syncs to serial interrupt inputs.
// - Sync triggers on rise; shutdown on fall or software trigger write.
// - Enabled pins interrupt on either transition.
`timescale 1ns/100ps
`default_nettype none
module pscx_ctrl #(
  parameter logic [23:0] VEC_FILL = 24'h000000
) (
  // Clock and resets
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic SW_RST_I,
  input wire logic WDT_RST_I,
  // Data memory register port
  input wire logic [pscx_pkg::ADDR_W-1:0] ADDR_I,
  input wire logic [pscx_pkg::DATA_W-1:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [pscx_pkg::DATA_W-1:0] RDATA_O,
  // Peripheral event inputs
  input wire logic PWM_SYNC_I,
  input wire logic PWM_SHUTDOWN_N_I,
  input wire logic [pscx_pkg::PIO_N-1:0] PIO_I,
  input wire logic WDT_STATE_I,
  input wire logic [1:0] PWM_TMR_I,
  // Core interrupt side
  input wire logic [4:0] CORE_REQ_I,
  input wire logic [pscx_pkg::SRC_N-1:0] CORE_MASK_I,
  output logic PERIPH_IRQ_N_O,
  output logic VEC_VALID_O,
  output logic [pscx_pkg::ADDR_W-1:0] VEC_ADDR_O,
  output logic PERIPH_RST_O,
  // Program RAM fill port
  output logic PM_WE_O,
  output logic [pscx_pkg::ADDR_W-1:0] PM_ADDR_O,
  output logic [pscx_pkg::PM_W-1:0] PM_DATA_O,
  output logic BOOT_DONE_O,
  // Mode outputs
  output logic [1:0] ADC_MUX_O,
  output logic ADC_CONVT_O,
  output logic PWM_DBL_UPD_O,
  output logic AUX_MODE_O,
  // Serial port pins
  input wire logic RX_PIN_A_I,
  input wire logic RX_PIN_B_I,
  input wire logic RFS_PIN_I,
  input wire logic TFS_PIN_I,
  input wire logic SCLK_PIN_I,
  input wire logic CORE_TX_I,
  input wire logic CORE_FLAG_OUT_I,
  input wire logic CORE_GFLAG_I,
  output logic SPORT_RX_O,
  output logic SPORT_RFS_O,
  output logic SPORT_SCLK_O,
  output logic TX_PIN_O,
  output logic FLAG_IN_O,
  output logic PIN5_O,
  output logic PIN5_OE_O,
  output logic SER_RX_IRQ_N_O,
  output logic SER_TX_IRQ_N_O
);
  import pscx_pkg::*;

  // ----------------------------------------
  // Reset and decode
  // ----------------------------------------
  logic srst;
  assign srst = SW_RST_I | WDT_RST_I;
  wire wr_mode = WR_I && (ADDR_I == MODE_ADDR);
  wire wr_ien_lo = WR_I && (ADDR_I == PIO_IEN_LO_ADDR);
  wire wr_ien_hi = WR_I && (ADDR_I == PIO_IEN_HI_ADDR);
  wire wr_swt = WR_I && (ADDR_I == SWT_ADDR);
  wire wr_sysctl = WR_I && (ADDR_I == SYSCTL_ADDR);
  wire rd_irq = RD_I && (ADDR_I == IRQSTAT_ADDR);
  wire rd_flg_lo = RD_I && (ADDR_I == PIO_FLG_LO_ADDR);
  wire rd_flg_hi = RD_I && (ADDR_I == PIO_FLG_HI_ADDR);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [8:0] mode_r;
  logic [15:0] sysctl_r;
  logic [8:0] pio_ien_r;
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      mode_r <= MODE_RST;
      sysctl_r <= SYSCTL_RST;
      pio_ien_r <= PIO_IEN_RST;
    end else if (srst) begin
      mode_r <= MODE_RST;
      sysctl_r <= SYSCTL_RST;
      pio_ien_r <= PIO_IEN_RST;
    end else begin
      if (wr_mode) begin
        mode_r <= WDATA_I[8:0];
      end
      if (wr_sysctl) begin
        sysctl_r <= WDATA_I;
      end
      if (wr_ien_lo) begin
        pio_ien_r[7:0] <= WDATA_I[7:0];
      end
      if (wr_ien_hi) begin
        pio_ien_r[8] <= WDATA_I[0];
      end
    end
  end
  wire rx_sel = mode_r[MODE_RXSEL_BIT];
  wire uart_en = mode_r[MODE_UART_BIT];
  wire alt_en = sysctl_r[SYSCTL_ALT_BIT];

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  logic [PIO_N+1:0] ev_in;
  logic [PIO_N+1:0] ev_rise;
  logic [PIO_N+1:0] ev_fall;
  assign ev_in = {PWM_SHUTDOWN_N_I, PWM_SYNC_I, PIO_I};
  pscx_edge #(.W(PIO_N + 2)) u_edge (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .clr_i(srst),
    .d_i(ev_in),
    .rise_o(ev_rise),
    .fall_o(ev_fall)
  );
  wire sync_ev = ev_rise[PIO_N] & mode_r[MODE_SYNCEN_BIT];
  wire trip_ev = (ev_fall[PIO_N+1] | wr_swt) & mode_r[MODE_TRIPEN_BIT];
  logic [PIO_N-1:0] pio_ev;
  assign pio_ev = (ev_rise[PIO_N-1:0] | ev_fall[PIO_N-1:0]) & pio_ien_r;

  // ----------------------------------------
  // Sticky flags, set beats read clear
  // ----------------------------------------
  logic [1:0] irq_flg_r;
  logic [PIO_N-1:0] pio_flg_r;
  logic [1:0] irq_flg_nxt;
  logic [PIO_N-1:0] pio_flg_nxt;
  logic [PIO_N-1:0] pio_keep;
  assign pio_keep = {~rd_flg_hi, {(PIO_N-1){~rd_flg_lo}}};
  assign irq_flg_nxt = (irq_flg_r & {2{~rd_irq}}) | {trip_ev, sync_ev};
  assign pio_flg_nxt = (pio_flg_r & pio_keep) | pio_ev;
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_flg_r <= 2'h0;
      pio_flg_r <= '0;
    end else if (srst) begin
      irq_flg_r <= 2'h0;
      pio_flg_r <= '0;
    end else begin
      irq_flg_r <= irq_flg_nxt;
      pio_flg_r <= pio_flg_nxt;
    end
  end
  wire pend_any = (|irq_flg_r) | (|pio_flg_r);

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  logic [15:0] rdata_nxt;
  wire [15:0] system_status_w = {12'h000, PWM_TMR_I, WDT_STATE_I, PWM_SHUTDOWN_N_I};
  assign rdata_nxt =
    (ADDR_I == PIO_IEN_LO_ADDR) ? {8'h00, pio_ien_r[7:0]} :
    (ADDR_I == PIO_FLG_LO_ADDR) ? {8'h00, pio_flg_r[7:0]} :
    (ADDR_I == PIO_IEN_HI_ADDR) ? {15'h0000, pio_ien_r[8]} :
    (ADDR_I == PIO_FLG_HI_ADDR) ? {15'h0000, pio_flg_r[8]} :
    (ADDR_I == MODE_ADDR) ? {7'h00, mode_r} :
    (ADDR_I == SYSTEM_STATUS_ADDR) ? system_status_w :
    (ADDR_I == IRQSTAT_ADDR) ? {14'h0000, irq_flg_r} :
    (ADDR_I == SYSCTL_ADDR) ? sysctl_r : 16'h0000;

  // ----------------------------------------
  // Vector selection
  // ----------------------------------------
  // Order: shutdown, sync, pin change, sw1, sw0, transmit, receive, timer
  logic [SRC_N-1:0] req;
  logic [SRC_N-1:0] req_on;
  logic [13:0] vec_nxt;
  assign req = {CORE_REQ_I, |pio_flg_r, irq_flg_r[IRQ_SYNC_BIT], irq_flg_r[IRQ_TRIP_BIT]};
  assign req_on = req & CORE_MASK_I;
  always_comb begin
    vec_nxt = 14'h0000;
    for (int i = SRC_N - 1; i >= 0; i--) begin
      if (req_on[i]) begin
        vec_nxt = VEC_ADDR[i];
      end
    end
  end

  // ----------------------------------------
  // Vector table fill after reset
  // ----------------------------------------
  // Words land four per source, so short handlers fit in place
  pscx_boot_t boot_r;
  pscx_boot_t boot_nxt;
  logic [13:0] pm_addr_r;
  logic [13:0] pm_addr_nxt;
  wire last_word = (pm_addr_r == VEC_LAST);
  always_comb begin
    boot_nxt = boot_r;
    pm_addr_nxt = pm_addr_r;
    unique case (boot_r)
      PSCX_BOOT_IDLE: begin
        boot_nxt = PSCX_BOOT_COPY;
        pm_addr_nxt = 14'h0000;
      end
      PSCX_BOOT_COPY: begin
        if (last_word) begin
          boot_nxt = PSCX_BOOT_DONE;
        end else begin
          pm_addr_nxt = pm_addr_r + 14'h0001;
        end
      end
      PSCX_BOOT_DONE: begin
        boot_nxt = PSCX_BOOT_DONE;
      end
      default: begin
        boot_nxt = PSCX_BOOT_IDLE;
      end
    endcase
  end
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      boot_r <= PSCX_BOOT_IDLE;
      pm_addr_r <= 14'h0000;
    end else if (srst) begin
      boot_r <= PSCX_BOOT_IDLE;
      pm_addr_r <= 14'h0000;
    end else begin
      boot_r <= boot_nxt;
      pm_addr_r <= pm_addr_nxt;
    end
  end

  // ----------------------------------------
  // Serial pin routing
  // ----------------------------------------
  wire rx_pick = rx_sel ? RX_PIN_B_I : RX_PIN_A_I;
  wire rfs_pick = uart_en ? rx_pick : RFS_PIN_I;

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  // One cycle of pin latency is the price of registered outputs
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RDATA_O <= 16'h0000;
      PERIPH_IRQ_N_O <= 1'b1;
      VEC_VALID_O <= 1'b0;
      VEC_ADDR_O <= 14'h0000;
      PERIPH_RST_O <= 1'b1;
      PM_WE_O <= 1'b0;
      PM_ADDR_O <= 14'h0000;
      PM_DATA_O <= 24'h000000;
      BOOT_DONE_O <= 1'b0;
      ADC_MUX_O <= 2'h0;
      ADC_CONVT_O <= 1'b0;
      PWM_DBL_UPD_O <= 1'b0;
      AUX_MODE_O <= 1'b0;
      SPORT_RX_O <= 1'b0;
      SPORT_RFS_O <= 1'b0;
      SPORT_SCLK_O <= 1'b0;
      TX_PIN_O <= 1'b0;
      FLAG_IN_O <= 1'b0;
      PIN5_O <= 1'b0;
      PIN5_OE_O <= 1'b0;
      SER_RX_IRQ_N_O <= 1'b1;
      SER_TX_IRQ_N_O <= 1'b1;
    end else begin
      RDATA_O <= RD_I ? rdata_nxt : 16'h0000;
      PERIPH_IRQ_N_O <= ~pend_any;
      VEC_VALID_O <= |req_on;
      VEC_ADDR_O <= vec_nxt;
      PERIPH_RST_O <= srst;
      PM_WE_O <= (boot_r == PSCX_BOOT_COPY);
      PM_ADDR_O <= pm_addr_r;
      PM_DATA_O <= VEC_FILL;
      BOOT_DONE_O <= (boot_r == PSCX_BOOT_DONE);
      ADC_MUX_O <= mode_r[MODE_ADCMUX_LSB +: 2];
      ADC_CONVT_O <= mode_r[MODE_CONVT_BIT];
      PWM_DBL_UPD_O <= mode_r[MODE_PWMUPD_BIT];
      AUX_MODE_O <= mode_r[MODE_AUXMODE_BIT];
      SPORT_RX_O <= alt_en ? 1'b0 : rx_pick;
      SPORT_RFS_O <= alt_en ? 1'b0 : rfs_pick;
      SPORT_SCLK_O <= SCLK_PIN_I;
      TX_PIN_O <= alt_en ? CORE_FLAG_OUT_I : CORE_TX_I;
      FLAG_IN_O <= alt_en & rx_pick;
      PIN5_O <= uart_en & CORE_GFLAG_I;
      PIN5_OE_O <= uart_en;
      SER_RX_IRQ_N_O <= alt_en ? RFS_PIN_I : 1'b1;
      SER_TX_IRQ_N_O <= alt_en ? TFS_PIN_I : 1'b1;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  sequence s_copy_start;
    boot_r == PSCX_BOOT_IDLE && !srst;
  endsequence
  sequence s_copy_run;
    ##2 PM_WE_O && PM_ADDR_O == 14'h0000;
  endsequence
  a_boot_fill_range: assert property (PM_WE_O |-> PM_ADDR_O <= VEC_LAST)
    else $error("fill write outside vector table");
  a_boot_fill_start: assert property (s_copy_start |-> s_copy_run)
    else $error("fill did not start at word zero");
  a_irq_line_low: assert property (pend_any && !srst |=> !PERIPH_IRQ_N_O)
    else $error("peripheral line high while pending");
  a_irq_line_idle: assert property (!pend_any |=> PERIPH_IRQ_N_O)
    else $error("peripheral line low with nothing pending");
  a_sync_sets: assert property (sync_ev && !srst |=> irq_flg_r[IRQ_SYNC_BIT])
    else $error("sync event lost");
  a_swt_trip: assert property (wr_swt && mode_r[MODE_TRIPEN_BIT] && !srst
    |=> irq_flg_r[IRQ_TRIP_BIT])
    else $error("software trigger did not set shutdown flag");
  a_read_clears: assert property (rd_irq && !sync_ev && !trip_ev |=> irq_flg_r == 2'h0)
    else $error("status read did not clear");
  a_set_wins: assert property (rd_flg_lo && pio_ev[0] && !srst |=> pio_flg_r[0])
    else $error("pin event lost in clearing read");
  a_pio_clear: assert property (rd_flg_lo && pio_ev[7:0] == 8'h00 |=> pio_flg_r[7:0] == 8'h00)
    else $error("pin flag read did not clear");
  a_rx_select: assert property (!alt_en && !uart_en && !srst
    |=> SPORT_RX_O == ($past(rx_sel) ? $past(RX_PIN_B_I) : $past(RX_PIN_A_I)))
    else $error("wrong receive pin routed");
  a_uart_tie: assert property (uart_en && !alt_en && !srst && !wr_mode
    |=> SPORT_RFS_O == SPORT_RX_O && PIN5_OE_O)
    else $error("uart tie broken");
  a_alt_irq: assert property (alt_en && !srst && !wr_sysctl
    |=> SER_RX_IRQ_N_O == $past(RFS_PIN_I))
    else $error("frame sync not routed to receive interrupt");
  a_vec_prio: assert property (req_on[0] |=> VEC_VALID_O && VEC_ADDR_O == 14'h002c)
    else $error("highest priority vector not chosen");
  a_vec_aligned: assert property (VEC_VALID_O |-> VEC_ADDR_O % VEC_WORDS == 0)
    else $error("vector not on a four word slot");
endmodule
`default_nettype wire

// ==== tb/pscx_core_model.sv ====
// Program RAM model of the core, filled by the boot copy
`timescale 1ns/100ps
`default_nettype none
module pscx_core_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill port
  input wire logic pm_we_i,
  input wire logic [13:0] pm_addr_i,
  input wire logic [23:0] pm_data_i,
  // Fill results
  output logic [7:0] fill_n_o,
  output logic [13:0] top_addr_o
);
  logic [23:0] pm_mem [0:511];
  // ----------------------------------------
  // Vector table store
  // ----------------------------------------
  // Four words a source, twelve slots
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_n_o <= 8'h00;
      top_addr_o <= 14'h0000;
    end else if (pm_we_i) begin
      pm_mem[pm_addr_i[8:0]] <= pm_data_i;
      fill_n_o <= fill_n_o + 8'h01;
      if (pm_addr_i > top_addr_o) begin
        top_addr_o <= pm_addr_i;
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb/pscx_ctrl_tb.sv ====
// Self-checking bench of the peripheral system controller
`timescale 1ns/100ps
`default_nettype none
module pscx_ctrl_tb;
  import pscx_pkg::*;
  logic clk = 1'b0, rst = 1'b1, sw_rst = 1'b0, wdt_rst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [13:0] addr = 14'h0000;
  logic [15:0] wdata = 16'h0000;
  logic sync = 1'b0, sd_n = 1'b1, wdt_st = 1'b0, seen = 1'b0;
  logic [8:0] pio = 9'h000;
  logic [1:0] tmr = 2'b00;
  logic [4:0] req = 5'h00;
  logic [7:0] mask = 8'h00;
  logic rxa = 1'b0, rxb = 1'b0, rfs = 1'b0, tfs = 1'b0, sclk = 1'b0;
  logic ctx = 1'b0, cfo = 1'b0, cgf = 1'b0;
  logic [13:0] cvec [0:4] = '{14'h0018, 14'h001c, 14'h0020, 14'h0024, 14'h0028};
  wire logic [15:0] rdata;
  wire logic [13:0] vec, pm_addr, top;
  wire logic [23:0] pm_data;
  wire logic [7:0] fill_n;
  wire logic [1:0] mux;
  wire logic irq_n, vec_v, prst, pm_we, done, convt, dbl, aux, s_rx, s_rfs, s_sclk;
  wire logic tx_pin, fl_in, p5, p5_oe, rx_irq_n, tx_irq_n;
  int err_total = 0;
  int n_tests = 0;
  always #10 clk = ~clk;
  pscx_ctrl dut (
    .CORE_CLK_I(clk), .RST_I(rst), .SW_RST_I(sw_rst), .WDT_RST_I(wdt_rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .PWM_SYNC_I(sync), .PWM_SHUTDOWN_N_I(sd_n), .PIO_I(pio), .WDT_STATE_I(wdt_st),
    .PWM_TMR_I(tmr), .CORE_REQ_I(req), .CORE_MASK_I(mask), .PERIPH_IRQ_N_O(irq_n),
    .VEC_VALID_O(vec_v), .VEC_ADDR_O(vec), .PERIPH_RST_O(prst), .PM_WE_O(pm_we),
    .PM_ADDR_O(pm_addr), .PM_DATA_O(pm_data), .BOOT_DONE_O(done), .ADC_MUX_O(mux),
    .ADC_CONVT_O(convt), .PWM_DBL_UPD_O(dbl), .AUX_MODE_O(aux), .RX_PIN_A_I(rxa),
    .RX_PIN_B_I(rxb), .RFS_PIN_I(rfs), .TFS_PIN_I(tfs), .SCLK_PIN_I(sclk), .CORE_TX_I(ctx),
    .CORE_FLAG_OUT_I(cfo), .CORE_GFLAG_I(cgf), .SPORT_RX_O(s_rx), .SPORT_RFS_O(s_rfs),
    .SPORT_SCLK_O(s_sclk), .TX_PIN_O(tx_pin), .FLAG_IN_O(fl_in), .PIN5_O(p5),
    .PIN5_OE_O(p5_oe), .SER_RX_IRQ_N_O(rx_irq_n), .SER_TX_IRQ_N_O(tx_irq_n));
  pscx_core_model core (.clk_i(clk), .rst_i(rst), .pm_we_i(pm_we), .pm_addr_i(pm_addr),
    .pm_data_i(pm_data), .fill_n_o(fill_n), .top_addr_o(top));
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Strobe dropped after one rising edge, then one idle cycle, so no register is written twice
  task automatic wr_r(input logic [13:0] a, input logic [15:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd_r(input logic [13:0] a, input logic [15:0] exp, input string nm);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    chk(nm, exp, rdata);
    cyc(1);
  endtask
  task automatic note(input string s);
    $display("Test %s done, mismatches %0d", s, err_total);
  endtask
  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #400000;
    err_total++;
    stop_test;
  end
  initial begin
    cyc(3);
    chk("irq_n_rst", 16'h0001, {15'h0, irq_n});
    chk("prst_rst", 16'h0001, {15'h0, prst});
    cyc(5);
    rst = 1'b0;
    for (int i = 0; i < 80 && done !== 1'b1; i++) cyc(1);
    chk("fill_n", 16'h0030, {8'h00, fill_n});
    chk("fill_top", 16'h002f, {2'b00, top});
    chk("fill_end", 16'h0001, {14'h0, pm_we, done});
    chk("fill_word", 16'h0000, pm_data[15:0]);
    rd_r(MODE_ADDR, 16'h0000, "mode_rst");
    rd_r(SYSCTL_ADDR, 16'h0000, "sysctl_rst");
    rd_r(PIO_IEN_LO_ADDR, 16'h0000, "ien_lo_rst");
    rd_r(PIO_IEN_HI_ADDR, 16'h0000, "ien_hi_rst");
    note("boot");
    sd_n = 1'b1;
    wdt_st = 1'b1;
    tmr = 2'b10;
    cyc(2);
    rd_r(SYSTEM_STATUS_ADDR, 16'h000b, "system_status");
    wr_r(SYSTEM_STATUS_ADDR, 16'h0000);
    rd_r(SYSTEM_STATUS_ADDR, 16'h000b, "system_status_ro");
    rd_r(14'h2014, 16'h0000, "unmapped");
    rd_r(SWT_ADDR, 16'h0000, "swt_wo");
    note("status");
    wr_r(MODE_ADDR, 16'h004f);
    chk("mode_out", 16'h001f, {11'h0, mux, convt, dbl, aux});
    rd_r(MODE_ADDR, 16'h004f, "mode_rd");
    rxb = 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr_r(MODE_ADDR, (s == 1) ? 16'h0010 : 16'h0000);
      chk("rx_sel", s[15:0], {15'h0, s_rx});
    end
    wr_r(MODE_ADDR, 16'h0030);
    cgf = 1'b1;
    ctx = 1'b1;
    cyc(2);
    chk("uart", 16'h001f, {11'h0, tx_pin, s_rx, s_rfs, p5_oe, p5});
    cgf = 1'b0;
    ctx = 1'b0;
    rxb = 1'b0;
    cyc(2);
    chk("uart2", 16'h0002, {11'h0, tx_pin, s_rx, s_rfs, p5_oe, p5});
    wr_r(SYSCTL_ADDR, 16'h0400);
    rxb = 1'b1;
    cfo = 1'b1;
    tfs = 1'b1;
    sclk = 1'b1;
    cyc(2);
    chk("alt", 16'h0036, {10'h0, fl_in, tx_pin, rx_irq_n, tx_irq_n, s_sclk, s_rx});
    rxb = 1'b0;
    cfo = 1'b0;
    rfs = 1'b1;
    tfs = 1'b0;
    sclk = 1'b0;
    cyc(2);
    chk("alt2", 16'h0008, {10'h0, fl_in, tx_pin, rx_irq_n, tx_irq_n, s_sclk, s_rx});
    rd_r(SYSCTL_ADDR, 16'h0400, "sysctl_rd");
    wr_r(SYSCTL_ADDR, 16'h0000);
    wr_r(MODE_ADDR, 16'h0000);
    note("routing");
    mask = 8'hff;
    sync = 1'b1;
    cyc(4);
    chk("sync_off", 16'h0001, {15'h0, irq_n});
    sync = 1'b0;
    wr_r(MODE_ADDR, 16'h0180);
    sync = 1'b1;
    cyc(4);
    chk("irq_low", 16'h0000, {15'h0, irq_n});
    chk("vec_sync", 16'h000c, {2'b00, vec});
    rd_r(IRQSTAT_ADDR, 16'h0001, "irq_sync");
    cyc(2);
    chk("irq_rel", 16'h0001, {15'h0, irq_n});
    sync = 1'b0;
    cyc(2);
    sync = 1'b1;
    sd_n = 1'b0;
    cyc(4);
    chk("vec_both", 16'h002c, {2'b00, vec});
    rd_r(IRQSTAT_ADDR, 16'h0003, "irq_both");
    sync = 1'b0;
    sd_n = 1'b1;
    wr_r(SWT_ADDR, 16'h0001);
    cyc(2);
    rd_r(IRQSTAT_ADDR, 16'h0002, "irq_swt");
    addr = IRQSTAT_ADDR;
    rd = 1'b1;
    sync = 1'b1;
    cyc(1);
    rd = 1'b0;
    cyc(3);
    rd_r(IRQSTAT_ADDR, 16'h0001, "set_wins");
    sync = 1'b0;
    note("pwm_irq");
    wr_r(PIO_IEN_LO_ADDR, 16'h0001);
    wr_r(PIO_IEN_HI_ADDR, 16'h0001);
    rd_r(PIO_IEN_LO_ADDR, 16'h0001, "ien_rd");
    pio = 9'h003;
    cyc(4);
    chk("pio_irq", 16'h0000, {15'h0, irq_n});
    chk("vec_pio", 16'h0008, {2'b00, vec});
    rd_r(PIO_FLG_LO_ADDR, 16'h0001, "flg_rise");
    pio = 9'h100;
    cyc(4);
    rd_r(PIO_FLG_LO_ADDR, 16'h0001, "flg_fall");
    chk("pio_pend", 16'h0000, {15'h0, irq_n});
    rd_r(PIO_FLG_HI_ADDR, 16'h0001, "flg_hi");
    cyc(2);
    chk("pio_rel", 16'h0001, {15'h0, irq_n});
    addr = PIO_FLG_LO_ADDR;
    rd = 1'b1;
    pio = 9'h101;
    cyc(1);
    rd = 1'b0;
    cyc(1);
    rd_r(PIO_FLG_LO_ADDR, 16'h0001, "pio_set_wins");
    note("pio_irq");
    for (int i = 0; i < 5; i++) begin
      req = 5'h01 << i;
      cyc(3);
      chk("core_vec", {2'b00, cvec[i]}, {2'b00, vec});
    end
    req = 5'h1f;
    cyc(3);
    chk("core_pri", 16'h0018, {2'b00, vec});
    chk("vec_on", 16'h0001, {15'h0, vec_v});
    mask = 8'hf7;
    cyc(3);
    chk("core_msk", 16'h001c, {2'b00, vec});
    mask = 8'h00;
    cyc(3);
    chk("none_pend", 16'h0000, {15'h0, vec_v});
    req = 5'h00;
    note("core_irq");
    for (int k = 0; k < 2; k++) begin
      wr_r(MODE_ADDR, 16'h004f);
      sw_rst = (k == 0);
      wdt_rst = (k == 1);
      cyc(1);
      sw_rst = 1'b0;
      wdt_rst = 1'b0;
      seen = prst;
      cyc(1);
      seen = seen | prst;
      chk("prst_pulse", 16'h0001, {15'h0, seen});
      chk("mode_clr", 16'h0000, {11'h0, mux, convt, dbl, aux});
      rd_r(MODE_ADDR, 16'h0000, "mode_srst");
      rd_r(PIO_IEN_LO_ADDR, 16'h0000, "ien_srst");
    end
    note("soft_reset");
    stop_test;
  end
endmodule
`default_nettype wire
